// ==== verilog/uart_pwr_pkg.sv ====
package uart_pwr_pkg;

    // ----------------------------------------
    // power saving modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_FIXED  = 2'b00,
        MODE_CYCLIC = 2'b01,
        MODE_RTS    = 2'b10,
        MODE_DTR    = 2'b11
    } psv_mode_type;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_IDLE   = 2'b01,
        ST_WAKE   = 2'b10
    } pwr_state_type;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] TIMEOUT_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET  = 8'h08;

    // ctrl fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_FLOW_BIT  = 2;
    localparam int CTRL_DACT_LSB  = 4;
    // status fields
    localparam int STAT_EN_BIT    = 0;
    localparam int STAT_ACT_BIT   = 1;
    localparam int STAT_ARM_BIT   = 2;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_BADCFG    = 8;

    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [15:0] TIMEOUT_RESET = 16'h07D0;
    localparam logic [15:0] TIMEOUT_MIN   = 16'h0028;
    localparam logic [15:0] TIMEOUT_MAX   = 16'hFDE8;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ      = 40_000_000;
    localparam int WAKE_US     = 20_000;
    localparam int FRAME_NS    = 4_615_000;
    localparam int WAKE_CYCLES = WAKE_US * (CLK_HZ / 1_000_000);
    localparam int FRAME_CYCLES = (FRAME_NS / 1000) * (CLK_HZ / 1_000_000) / 1000;

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef struct packed {
        logic ring_ind;
        logic tx_pending;
        logic data_call;
        logic voice_call;
        logic usb_active;
    } activity_type;

endpackage

// ==== verilog/uart_line_power_saving.sv ====
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - rts-controlled mode accepted only with flow control off
// - rts off disables port at once; idle then allowed
// - port still enabled for transmit and data calls; variant a also voice
// - rts off-to-on re-enables port; idle returns active after wake time
// - rts on keeps port enabled and blocks idle
// - variant a refuses dtr-controlled mode
// - dtr-controlled mode allowed with any flow control setting
// - dtr off disables port at once; dtr on keeps it enabled
// - dtr off-to-on re-enables port; idle returns active after wake time
// - dtr control actions still applied per terminal action setting
// - cts shows port enable with flow control; variant a also rts mode
// - armed wake: rx rising edge wakes, active within wake time
// - wake character discarded; host waits wake time before data
// - wake armed in cyclic mode without flow control; variant a also rts off
// - variant b drops rx data and disarms wake in rts/dtr off
// - variant a keeps port on after rts-mode wake for inactivity timeout
// - data wake cannot be switched off
// - host sends dummy prefix; device treats it as wake when idle with wake armed
// - data calls keep port enabled, variant a also voice; host sends no dummy prefix in data mode
// - variant b stays active with usb up; mode still governs port
// - inactivity timeout in frames 40..65000, default 2000, restarted per char
// - cts low means port enabled, high means disabled
module uart_line_power_saving #(
    parameter bit          VARIANT_B    = 1'b0,
    parameter int unsigned WAKE_CYCLES  = uart_pwr_pkg::WAKE_CYCLES,
    parameter int unsigned FRAME_CYCLES = uart_pwr_pkg::FRAME_CYCLES
) (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // serial line, on = high at these ports except cts_n, which is low when on
    input  wire logic                      rts_on,
    input  wire logic                      dtr_on,
    input  wire logic                      rxd,
    input  wire logic                      rx_char_strobe,
    output logic                           cts_n,
    // module side
    input  wire uart_pwr_pkg::activity_type activity,
    output logic                           port_enable,
    output logic                           module_active,
    output logic                           rx_accept,
    output logic                           dtr_action_strobe,
    output logic [1:0]                     dtr_action
);

    if (WAKE_CYCLES < 1 || FRAME_CYCLES < 1) begin : g_bad_counts
        $error("cycle counts must be at least one");
    end

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic [1:0]  mode_reg;
    logic        flow_on_reg;
    logic [1:0]  dact_reg;
    logic [15:0] timeout_reg;
    logic        badcfg_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;
    logic [1:0]  mode_next;
    logic        flow_next;
    logic        cfg_ok;

    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign mode_next = wstrb_reg[0] ? wdata_reg[uart_pwr_pkg::CTRL_MODE_LSB +: 2] : mode_reg;
    assign flow_next = wstrb_reg[0] ? wdata_reg[uart_pwr_pkg::CTRL_FLOW_BIT] : flow_on_reg;
    // rts mode needs flow off; dtr mode only on variant b
    assign cfg_ok = !((mode_next == uart_pwr_pkg::MODE_RTS) && flow_next)
                 && !((mode_next == uart_pwr_pkg::MODE_DTR) && !VARIANT_B);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg     <= uart_pwr_pkg::CTRL_RESET[1:0];
            flow_on_reg  <= 1'b0;
            dact_reg     <= 2'b00;
            timeout_reg  <= uart_pwr_pkg::TIMEOUT_RESET;
            badcfg_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= uart_pwr_pkg::AXI_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= uart_pwr_pkg::AXI_OKAY;
                case (awaddr_reg)
                    uart_pwr_pkg::CTRL_OFFSET: begin
                        // refused setting keeps the old one; flagged for software
                        if (cfg_ok) begin
                            mode_reg    <= mode_next;
                            flow_on_reg <= flow_next;
                            if (wstrb_reg[0])
                                dact_reg <= wdata_reg[uart_pwr_pkg::CTRL_DACT_LSB +: 2];
                        end
                        badcfg_reg <= !cfg_ok;
                    end
                    uart_pwr_pkg::TIMEOUT_OFFSET: begin
                        if (wstrb_reg[1:0] == 2'b11 &&
                            wdata_reg[15:0] >= uart_pwr_pkg::TIMEOUT_MIN &&
                            wdata_reg[15:0] <= uart_pwr_pkg::TIMEOUT_MAX)
                            timeout_reg <= wdata_reg[15:0];
                        else
                            s_axi_bresp <= uart_pwr_pkg::AXI_SLVERR;
                    end
                    default: s_axi_bresp <= uart_pwr_pkg::AXI_SLVERR;
                endcase
            end
        end
    end

    // ----------------------------------------
    // power state
    // ----------------------------------------
    uart_pwr_pkg::pwr_state_type state_reg;
    logic        rts_prev_reg;
    logic        dtr_prev_reg;
    logic        rxd_prev_reg;
    logic [31:0] wake_cnt_reg;
    logic [31:0] frame_cnt_reg;
    logic [15:0] idle_cnt_reg;
    logic        linger_reg;
    logic        hold_on;
    logic        wake_armed;
    logic        line_off;
    logic        rx_rise;
    logic        line_rise;
    logic        want_port;
    logic        voice_ok;

    assign voice_ok  = !VARIANT_B && activity.voice_call;
    assign line_off  = (mode_reg == uart_pwr_pkg::MODE_RTS && !rts_on)
                    || (mode_reg == uart_pwr_pkg::MODE_DTR && !dtr_on);
    // controlling line on keeps port up and forbids idle
    assign hold_on   = mode_reg == uart_pwr_pkg::MODE_FIXED
                    || (mode_reg == uart_pwr_pkg::MODE_RTS && rts_on)
                    || (mode_reg == uart_pwr_pkg::MODE_DTR && dtr_on);
    // always derived from mode, never from a software switch
    assign wake_armed = (mode_reg == uart_pwr_pkg::MODE_CYCLIC && !flow_on_reg)
                     || (!VARIANT_B && mode_reg == uart_pwr_pkg::MODE_RTS && !rts_on);
    assign rx_rise   = rxd && !rxd_prev_reg;
    assign line_rise = (mode_reg == uart_pwr_pkg::MODE_RTS && rts_on && !rts_prev_reg)
                    || (mode_reg == uart_pwr_pkg::MODE_DTR && dtr_on && !dtr_prev_reg);
    assign want_port = hold_on || activity.tx_pending || activity.data_call || voice_ok
                    || linger_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rts_prev_reg <= 1'b0;
            dtr_prev_reg <= 1'b0;
            rxd_prev_reg <= 1'b1;
        end else begin
            rts_prev_reg <= rts_on;
            dtr_prev_reg <= dtr_on;
            rxd_prev_reg <= rxd;
        end
    end

    // inactivity timer in frames, restarted by every accepted character
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_cnt_reg <= 32'h0000_0000;
            idle_cnt_reg  <= 16'h0000;
            linger_reg    <= 1'b0;
        end else if ((rx_char_strobe && rx_accept) || (wake_armed && rx_rise &&
                     state_reg == uart_pwr_pkg::ST_IDLE)) begin
            frame_cnt_reg <= 32'h0000_0000;
            idle_cnt_reg  <= 16'h0000;
            // cyclic mode and variant a rts mode with rts off linger after data
            linger_reg    <= wake_armed || mode_reg == uart_pwr_pkg::MODE_CYCLIC;
        end else if (linger_reg) begin
            if (frame_cnt_reg == FRAME_CYCLES - 1) begin
                frame_cnt_reg <= 32'h0000_0000;
                idle_cnt_reg  <= idle_cnt_reg + 16'h0001;
                if (idle_cnt_reg + 16'h0001 >= timeout_reg)
                    linger_reg <= 1'b0;
            end else begin
                frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // usb link on variant b keeps module awake only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= uart_pwr_pkg::ST_ACTIVE;
            wake_cnt_reg <= 32'h0000_0000;
            port_enable  <= 1'b1;
        end else begin
            case (state_reg)
                uart_pwr_pkg::ST_ACTIVE: begin
                    port_enable <= want_port;
                    if (!want_port && !(VARIANT_B && activity.usb_active))
                        state_reg <= uart_pwr_pkg::ST_IDLE;
                end
                uart_pwr_pkg::ST_IDLE: begin
                    port_enable <= 1'b0;
                    if (line_rise || want_port || (wake_armed && rx_rise) ||
                        (VARIANT_B && activity.usb_active)) begin
                        state_reg    <= uart_pwr_pkg::ST_WAKE;
                        wake_cnt_reg <= 32'h0000_0000;
                    end
                end
                uart_pwr_pkg::ST_WAKE: begin
                    // port stays off so the wake character is lost
                    if (wake_cnt_reg == WAKE_CYCLES - 1) begin
                        state_reg   <= uart_pwr_pkg::ST_ACTIVE;
                        port_enable <= 1'b1;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg + 32'h0000_0001;
                    end
                end
                default: state_reg <= uart_pwr_pkg::ST_ACTIVE;
            endcase
        end
    end

    // ----------------------------------------
    // outputs and status
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_active     <= 1'b1;
            rx_accept         <= 1'b1;
            cts_n             <= 1'b0;
            dtr_action_strobe <= 1'b0;
            dtr_action        <= 2'b00;
        end else begin
            module_active <= state_reg == uart_pwr_pkg::ST_ACTIVE;
            // wake char never accepted; variant b drops all on line off
            rx_accept <= state_reg == uart_pwr_pkg::ST_ACTIVE && want_port
                      && !(VARIANT_B && line_off);
            if (flow_on_reg && (mode_reg == uart_pwr_pkg::MODE_DTR ||
                mode_reg == uart_pwr_pkg::MODE_CYCLIC || (!VARIANT_B &&
                mode_reg == uart_pwr_pkg::MODE_RTS)))
                cts_n <= !(port_enable && state_reg == uart_pwr_pkg::ST_ACTIVE);
            else
                cts_n <= 1'b0;
            // dtr edges still reach the action logic in every mode
            dtr_action_strobe <= dtr_on != dtr_prev_reg;
            dtr_action        <= dact_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= uart_pwr_pkg::AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= uart_pwr_pkg::AXI_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                case (s_axi_araddr)
                    uart_pwr_pkg::CTRL_OFFSET: begin
                        s_axi_rdata[uart_pwr_pkg::CTRL_MODE_LSB +: 2] <= mode_reg;
                        s_axi_rdata[uart_pwr_pkg::CTRL_FLOW_BIT]      <= flow_on_reg;
                        s_axi_rdata[uart_pwr_pkg::CTRL_DACT_LSB +: 2] <= dact_reg;
                    end
                    uart_pwr_pkg::TIMEOUT_OFFSET: s_axi_rdata[15:0] <= timeout_reg;
                    uart_pwr_pkg::STATUS_OFFSET: begin
                        s_axi_rdata[uart_pwr_pkg::STAT_EN_BIT]  <= port_enable;
                        s_axi_rdata[uart_pwr_pkg::STAT_ACT_BIT] <= module_active;
                        s_axi_rdata[uart_pwr_pkg::STAT_ARM_BIT] <= wake_armed;
                        s_axi_rdata[uart_pwr_pkg::STAT_STATE_LSB +: 2] <= state_reg;
                        s_axi_rdata[uart_pwr_pkg::STAT_BADCFG]  <= badcfg_reg;
                    end
                    default: s_axi_rresp <= uart_pwr_pkg::AXI_SLVERR;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_wake_done;
        state_reg == uart_pwr_pkg::ST_WAKE ##1 state_reg == uart_pwr_pkg::ST_ACTIVE;
    endsequence

    sequence s_armed_rise;
        state_reg == uart_pwr_pkg::ST_IDLE && wake_armed && rx_rise;
    endsequence

    a_rts_hold_port: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_reg == uart_pwr_pkg::MODE_RTS && rts_on && state_reg == uart_pwr_pkg::ST_ACTIVE)
        |=> port_enable)
        else $error("rts on did not keep port enabled");
    a_rts_cfg_flow: assert property (@(posedge aclk) disable iff (!aresetn)
        !(mode_reg == uart_pwr_pkg::MODE_RTS && flow_on_reg))
        else $error("rts mode with flow control on");
    a_dtr_variant: assert property (@(posedge aclk) disable iff (!aresetn)
        !(!VARIANT_B && mode_reg == uart_pwr_pkg::MODE_DTR))
        else $error("dtr mode on variant a");
    a_line_off_port: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == uart_pwr_pkg::ST_ACTIVE && !want_port) |=> !port_enable)
        else $error("port not disabled when line off");
    a_wake_drops: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == uart_pwr_pkg::ST_WAKE) |=> !rx_accept)
        else $error("data accepted during wake");
    a_cts_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == uart_pwr_pkg::ST_IDLE && flow_on_reg &&
         (mode_reg == uart_pwr_pkg::MODE_DTR ||
          mode_reg == uart_pwr_pkg::MODE_CYCLIC)) |=> cts_n)
        else $error("cts not off while idle");
    a_idle_leave: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == uart_pwr_pkg::ST_IDLE && line_rise) |=>
        state_reg == uart_pwr_pkg::ST_WAKE)
        else $error("line rise did not start wake");
    a_b_drop_rx: assert property (@(posedge aclk) disable iff (!aresetn)
        (VARIANT_B && line_off) |=> !rx_accept)
        else $error("variant b accepted data with line off");
    a_rx_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        s_armed_rise |=> state_reg == uart_pwr_pkg::ST_WAKE)
        else $error("armed rx edge did not start wake");
    a_wake_end: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wake_done |-> port_enable)
        else $error("port not enabled at end of wake");
    a_wake_port_off: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == uart_pwr_pkg::ST_WAKE |-> !port_enable)
        else $error("port enabled during wake");
    a_idle_no_port: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == uart_pwr_pkg::ST_IDLE |-> !port_enable)
        else $error("port enabled while idle");
    a_cts_active: assert property (@(posedge aclk) disable iff (!aresetn)
        (port_enable && state_reg == uart_pwr_pkg::ST_ACTIVE) |=> !cts_n)
        else $error("cts off while port enabled");

endmodule // uart_line_power_saving

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // requests from the bench
    input  wire logic rts_req,
    input  wire logic dtr_req,
    input  wire logic wake_req,
    // serial line toward the device
    output logic      rts_on,
    output logic      dtr_on,
    output logic      rxd,
    output logic      rx_char_strobe
);
    logic [3:0] bit_cnt;
    // ----------------------------------------
    // host line driving
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        rts_on <= rts_req;
        dtr_on <= dtr_req;
    end
    // wake character: start bit low, back to idle high; only that rising edge counts
    always_ff @(posedge aclk) begin
        rx_char_strobe <= 1'b0;
        if (!aresetn) begin
            bit_cnt <= 4'h0;
            rxd     <= 1'b1;
        end else if (wake_req) begin
            bit_cnt <= 4'h8;
            rxd     <= 1'b0;
        end else if (bit_cnt != 4'h0) begin
            bit_cnt <= bit_cnt - 4'h1;
            if (bit_cnt == 4'h1) begin
                rxd            <= 1'b1;
                rx_char_strobe <= 1'b1;
            end
        end
    end
endmodule // host_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int WAKE = 20;
    logic aclk = 1'b0, aresetn = 1'b0, rts_req = 1'b1, dtr_req = 1'b1, wake_req = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic rts_on, dtr_on, rxd, rx_char_strobe, cts_n, port_enable, module_active;
    logic rx_accept, rx_accept_b, dtr_action_strobe;
    logic [1:0] dtr_action;
    uart_pwr_pkg::activity_type activity = '0;
    int failures = 0;
    int comparisons = 0;

    always #12.5 aclk = ~aclk;

    host_model host (.aclk(aclk), .aresetn(aresetn), .rts_req(rts_req), .dtr_req(dtr_req),
        .wake_req(wake_req), .rts_on(rts_on), .dtr_on(dtr_on), .rxd(rxd),
        .rx_char_strobe(rx_char_strobe));

    uart_line_power_saving #(.VARIANT_B(1'b0), .WAKE_CYCLES(WAKE), .FRAME_CYCLES(4)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rts_on(rts_on), .dtr_on(dtr_on), .rxd(rxd),
        .rx_char_strobe(rx_char_strobe), .cts_n(cts_n), .activity(activity),
        .port_enable(port_enable), .module_active(module_active), .rx_accept(rx_accept),
        .dtr_action_strobe(dtr_action_strobe), .dtr_action(dtr_action));

    // variant b on the same inputs; its bus answers are ignored and differ once it accepts the dtr mode write
    uart_line_power_saving #(.VARIANT_B(1'b1), .WAKE_CYCLES(WAKE), .FRAME_CYCLES(4)) dut_b (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready(s_axi_rready), .rts_on(rts_on), .dtr_on(dtr_on),
        .rxd(rxd), .rx_char_strobe(rx_char_strobe), .cts_n(), .activity(activity),
        .port_enable(), .module_active(), .rx_accept(rx_accept_b), .dtr_action_strobe(),
        .dtr_action());

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic summarize;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // address and data offered together; bready stays up until bvalid is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (n >= 100) begin
            failures++;
            summarize();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (n >= 100) begin
            failures++;
            summarize();
        end
    endtask

    // bounded wait on the port enable; running out is a mismatch
    task automatic wait_en(input int max, input logic v);
        int n;
        n = 0;
        while (port_enable !== v && n < max) begin
            @(posedge aclk);
            n++;
        end
        check({31'h0, port_enable}, {31'h0, v});
        if (port_enable !== v) summarize();
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({29'h0, cts_n, module_active, port_enable}, 32'h3);
        axi_rd(8'h04);
        check(d, 32'h7D0);
        axi_rd(8'h0C);
        check({30'h0, r}, 32'h2);
        axi_wr(8'h04, 32'h27);
        check({30'h0, r}, 32'h2);
        axi_wr(8'h04, 32'h28);
        check({30'h0, r}, 32'h0);
        axi_wr(8'h00, 32'h3);
        axi_rd(8'h00);
        check(d, 32'h0);
        axi_rd(8'h08);
        check({31'h0, d[8]}, 32'h1);
        axi_wr(8'h00, 32'h6);
        axi_rd(8'h00);
        check(d, 32'h0);
        axi_wr(8'h00, 32'h2);
        axi_rd(8'h00);
        check(d, 32'h2);
        repeat (300) @(posedge aclk);
        check({30'h0, module_active, port_enable}, 32'h3);
        rts_req <= 1'b0;
        wait_en(10, 1'b0);
        check({30'h0, rx_accept, rx_accept_b}, 32'h0);
        activity.tx_pending <= 1'b1;
        wait_en(WAKE + 10, 1'b1);
        @(posedge aclk);
        check({30'h0, rx_accept, rx_accept_b}, 32'h2);
        activity.tx_pending <= 1'b0;
        wait_en(10, 1'b0);
        repeat (50) @(posedge aclk);
        rts_req <= 1'b1;
        wait_en(WAKE + 10, 1'b1);
        axi_wr(8'h00, 32'h1);
        wait_en(400, 1'b0);
        axi_rd(8'h08);
        check({31'h0, d[2]}, 32'h1);
        wake_req <= 1'b1;
        @(posedge aclk);
        wake_req <= 1'b0;
        wait_en(WAKE + 20, 1'b1);
        @(posedge aclk);
        check({31'h0, rx_accept}, 32'h1);
        axi_wr(8'h00, 32'h25);
        wait_en(400, 1'b0);
        @(posedge aclk);
        check({31'h0, cts_n}, 32'h1);
        dtr_req <= 1'b0;
        repeat (3) @(posedge aclk);
        check({29'h0, dtr_action_strobe, dtr_action}, 32'h6);
        summarize();
    end
endmodule // tb_top
